// ===== hdl/jump_seq_pkg.sv
// Package for the jump and subroutine sequencer
`default_nettype none
package jump_seq_pkg;
   localparam int word_width = 16;
   localparam int page_bit = 10;
   localparam int indirect_bit = 15;
   localparam int offset_width = 10;
   localparam logic [15:0] pc_reset = 16'h0000;
   localparam logic [3:0] opcode_jump = 4'h5;
   localparam logic [3:0] opcode_call = 4'h3;
   localparam logic [15:0] word_no_operation = 16'h0000;
   localparam logic [15:0] word_halt_instruction = 16'h8400;
   typedef enum {
      st_fetch,
      st_indirect,
      st_execute,
      st_halted
   } phase_type;
   typedef enum logic [2:0] {
      op_other,
      op_no_operation,
      op_unconditional_jump,
      op_subroutine_call,
      op_halt_instruction
   } op_type;
   typedef struct packed {
      op_type op;
      logic indirect;
      logic current_page;
      logic [9:0] offset;
   } decoded_type;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic we;
   } mem_req_type;
endpackage
`default_nettype wire

// ===== hdl/instr_decode.sv
// Instruction word decoder for jump, call, no-operation and halt
`default_nettype none
module instr_decode
   import jump_seq_pkg::*;
(
   input wire logic [15:0] word_i,
   output var decoded_type dec_o
);
   always_comb
   begin
      dec_o.indirect = word_i[indirect_bit];
      dec_o.current_page = word_i[page_bit];
      dec_o.offset = word_i[offset_width-1:0];
      if (word_i == word_no_operation)
      begin
         dec_o.op = op_no_operation;
      end
      else if (word_i == word_halt_instruction)
      begin
         dec_o.op = op_halt_instruction;
      end
      else if (word_i[14:11] == opcode_jump)
      begin
         dec_o.op = op_unconditional_jump;
      end
      else if (word_i[14:11] == opcode_call)
      begin
         dec_o.op = op_subroutine_call;
      end
      else
      begin
         dec_o.op = op_other;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/jump_subroutine_sequencer.sv
// Program flow sequencer for jump and subroutine call instructions
//
// Overview of operation
// - Jump loads program counter with target
// - Direct jump finishes in one phase
// - Instructions other than jump, call and halt advance program counter by one
// - Execute end: increment address, copy to counter
// - Call fetch addresses target, counter unchanged
// - Call execute phase stores return address
// - After call both registers hold target+1
// - Return address is caller+1, kept in transfer
// - Page zero or current page direct, indirect to 0000-7FFF
// - Indirect call resolves like indirect jump
// - Indirect phase uses fetched word as address
// - Decode 026200 jump, 016773 call
// - Decode 126773 as indirect jump
// - All-zero word is no operation
// - Bit 10 clear forces page zero
// - Bit 15 on a jump or call inserts an indirect phase
`default_nettype none
module jump_subroutine_sequencer
   import jump_seq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [15:0] start_addr_i,
   input wire logic [15:0] mem_rdata_i,
   output var mem_req_type mem_o,
   output logic [15:0] pc_o,
   output logic [15:0] transfer_o,
   output logic indirect_o,
   output logic halted_o
);
   typedef struct packed {
      phase_type phase;
      logic [15:0] pc;
      logic [15:0] mar;
      logic [15:0] tr;
      logic [15:0] instr;
      logic we;
      logic [15:0] wdata;
      logic ind;
      logic halt_instruction;
   } state_type;

   state_type s_q;
   state_type s_d;
   decoded_type dec;
   logic [15:0] target;
   logic [15:0] pc_next;

   // Decoded from the live memory word during fetch only
   instr_decode u_dec (
      .word_i(mem_rdata_i),
      .dec_o(dec)
   );

   // Page bits come from the address register, not the counter
   assign target = dec.current_page ? {s_q.mar[15:10], dec.offset} : {6'h00, dec.offset};
   assign pc_next = 16'(s_q.pc + 16'h0001);

   always_comb
   begin
      s_d = s_q;
      s_d.we = 1'b0;
      if (start_i)
      begin
         s_d.phase = st_fetch;
         s_d.pc = start_addr_i;
         s_d.mar = start_addr_i;
      end
      else
      begin
         case (s_q.phase)
            st_fetch:
            begin
               s_d.instr = mem_rdata_i;
               s_d.tr = mem_rdata_i;
               case (dec.op)
                  op_unconditional_jump:
                  begin
                     if (dec.indirect)
                     begin
                        s_d.mar = target;
                        s_d.phase = st_indirect;
                     end
                     else
                     begin
                        s_d.pc = target;
                        s_d.mar = target;
                     end
                  end
                  op_subroutine_call:
                  begin
                     s_d.mar = target;
                     if (dec.indirect)
                     begin
                        s_d.phase = st_indirect;
                     end
                     else
                     begin
                        // Store launched now, so it hits the target while still addressed
                        s_d.we = 1'b1;
                        s_d.wdata = pc_next;
                        s_d.phase = st_execute;
                     end
                  end
                  op_halt_instruction:
                  begin
                     s_d.phase = st_halted;
                  end
                  default:
                  begin
                     s_d.pc = pc_next;
                     s_d.mar = pc_next;
                  end
               endcase
            end
            st_indirect:
            begin
               s_d.tr = mem_rdata_i;
               if (mem_rdata_i[indirect_bit])
               begin
                  s_d.mar = {1'b0, mem_rdata_i[14:0]};
               end
               else if (s_q.instr[14:11] == opcode_jump)
               begin
                  s_d.pc = mem_rdata_i;
                  s_d.mar = mem_rdata_i;
                  s_d.phase = st_fetch;
               end
               else
               begin
                  s_d.mar = mem_rdata_i;
                  s_d.we = 1'b1;
                  s_d.wdata = pc_next;
                  s_d.phase = st_execute;
               end
            end
            st_execute:
            begin
               // Strobe drops here; the store lands on this edge
               s_d.tr = pc_next;
               s_d.pc = 16'(s_q.mar + 16'h0001);
               s_d.mar = 16'(s_q.mar + 16'h0001);
               s_d.phase = st_fetch;
            end
            st_halted:
            begin
               s_d.phase = st_halted;
            end
            default:
            begin
               s_d.phase = st_fetch;
            end
         endcase
      end
      // Flags registered so the outputs come straight from flops
      s_d.ind = (s_d.phase == st_indirect);
      s_d.halt_instruction = (s_d.phase == st_halted);
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s_q <= '{phase: st_fetch, pc: pc_reset, mar: pc_reset, tr: 16'h0000,
                  instr: 16'h0000, we: 1'b0, wdata: 16'h0000, ind: 1'b0, halt_instruction: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Address register always drives memory, so no extra write cycle is needed
   assign mem_o = '{addr: s_q.mar, wdata: s_q.wdata, we: s_q.we};
   assign pc_o = s_q.pc;
   assign transfer_o = s_q.tr;
   assign indirect_o = s_q.ind;
   assign halted_o = s_q.halt_instruction;

   property p_direct_jump;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_fetch && dec.op == op_unconditional_jump && !dec.indirect)
      |=> (pc_o == $past(target) && s_q.mar == $past(target) && s_q.phase == st_fetch);
   endproperty
   a_direct_jump: assert property (p_direct_jump) else $error("direct jump target wrong");

   property p_advance;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_fetch && dec.op == op_no_operation)
      |=> (pc_o == 16'($past(pc_o) + 16'h0001) && s_q.mar == pc_o);
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not advance");

   property p_call_fetch;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_fetch && dec.op == op_subroutine_call && !dec.indirect)
      |=> (pc_o == $past(pc_o) && s_q.phase == st_execute);
   endproperty
   a_call_fetch: assert property (p_call_fetch) else $error("call fetch moved counter");

   property p_call_store;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_execute)
      |-> (mem_o.we && mem_o.addr == s_q.mar && mem_o.wdata == 16'(pc_o + 16'h0001));
   endproperty
   a_call_store: assert property (p_call_store) else $error("return address store wrong");

   property p_call_done;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_execute)
      |=> (pc_o == 16'($past(s_q.mar) + 16'h0001) && s_q.mar == pc_o && !mem_o.we
           && transfer_o == 16'($past(pc_o) + 16'h0001));
   endproperty
   a_call_done: assert property (p_call_done) else $error("call completion wrong");

   property p_page_zero;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_fetch && dec.op == op_subroutine_call && !dec.current_page)
      |=> (s_q.mar[15:10] == 6'h00);
   endproperty
   a_page_zero: assert property (p_page_zero) else $error("page zero not forced");

   property p_indirect_enter;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && s_q.phase == st_fetch && dec.indirect
       && (dec.op == op_unconditional_jump || dec.op == op_subroutine_call))
      |=> indirect_o;
   endproperty
   a_indirect_enter: assert property (p_indirect_enter) else $error("indirect phase missing");

   property p_indirect_chain;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && indirect_o && mem_rdata_i[15]) |=> (indirect_o && s_q.mar == {1'b0, $past(mem_rdata_i[14:0])});
   endproperty
   a_indirect_chain: assert property (p_indirect_chain) else $error("indirect chain broken");

   property p_indirect_jump;
      @(posedge clk_sys_i) disable iff (reset_i)
      (!start_i && indirect_o && !mem_rdata_i[15] && s_q.instr[14:11] == opcode_jump)
      |=> (pc_o == $past(mem_rdata_i) && s_q.mar == pc_o && s_q.phase == st_fetch);
   endproperty
   a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong");
endmodule
`default_nettype wire

// ===== test/core_memory.sv
// Core memory model facing the sequencer
`default_nettype none
module core_memory
   import jump_seq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire mem_req_type mem_i,
   output logic [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:65535];
   initial
   begin
      foreach (mem[a])
         mem[a] = 16'h0000;
   end
   // Combinational read, sampled by the sequencer in the same cycle
   assign rdata_o = mem[mem_i.addr];
   always @(posedge clk_sys_i)
   begin
      if (mem_i.we)
         mem[mem_i.addr] <= mem_i.wdata;
   end
endmodule
`default_nettype wire

// ===== test/jump_subroutine_sequencer_test.sv
// Self-checking bench for the jump sequencer
`default_nettype none
module jump_subroutine_sequencer_test
   import jump_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic start_i = 1'b0;
   logic [15:0] start_addr_i = 16'h0000;
   logic [15:0] rdata;
   mem_req_type req;
   logic [15:0] pc;
   logic [15:0] tr;
   logic ind;
   logic halt_instruction;
   int errors = 0;
   int n_checks = 0;

   jump_subroutine_sequencer DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .start_i(start_i),
      .start_addr_i(start_addr_i), .mem_rdata_i(rdata), .mem_o(req), .pc_o(pc), .transfer_o(tr),
      .indirect_o(ind), .halted_o(halt_instruction));
   core_memory MEM (.clk_sys_i(clk_sys_i), .mem_i(req), .rdata_o(rdata));

   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic step;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic ld(input logic [15:0] a, input logic [15:0] v);
      MEM.mem[a] = v;
   endtask

   // Level start held for one edge only
   task automatic go(input logic [15:0] a);
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      start_addr_i <= a;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      #1;
   endtask

   task automatic t_program;
      ld(16'h0441, 16'h2c80);
      ld(16'h0482, 16'h1dfb);
      ld(16'h0483, 16'h8400);
      ld(16'h05fd, 16'hadfb);
      go(16'h0440);
      step;
      chk16(pc, 16'h0441);
      step;
      chk16(pc, 16'h0480);
      chk16(req.addr, 16'h0480);
      step;
      step;
      chk16(req.addr, 16'h0482);
      step;
      chk16(pc, 16'h0482);
      chk16(req.addr, 16'h05fb);
      chk1(req.we, 1'b1);
      chk16(req.wdata, 16'h0483);
      step;
      chk16(pc, 16'h05fc);
      chk16(tr, 16'h0483);
      chk1(req.we, 1'b0);
      chk16(req.addr, 16'h05fc);
      chk16(MEM.mem[16'h05fb], 16'h0483);
      step;
      step;
      chk1(ind, 1'b1);
      chk16(req.addr, 16'h05fb);
      step;
      chk16(pc, 16'h0483);
      chk16(req.addr, 16'h0483);
      chk1(ind, 1'b0);
      step;
      chk1(halt_instruction, 1'b1);
   endtask

   task automatic t_pages;
      ld(16'h0c40, 16'h2923);
      ld(16'h4440, 16'h2c80);
      go(16'h0c40);
      chk1(halt_instruction, 1'b0);
      step;
      chk16(pc, 16'h0123);
      go(16'h4440);
      step;
      chk16(req.addr, 16'h4480);
   endtask

   // Indirect call via page zero with a two-level chain
   task automatic t_chain;
      ld(16'h1000, 16'h9850);
      ld(16'h0050, 16'h8060);
      ld(16'h0060, 16'h3abc);
      go(16'h1000);
      step;
      chk1(ind, 1'b1);
      chk16(req.addr, 16'h0050);
      step;
      chk1(ind, 1'b1);
      chk16(req.addr, 16'h0060);
      step;
      chk1(ind, 1'b0);
      chk16(req.addr, 16'h3abc);
      chk1(req.we, 1'b1);
      chk16(req.wdata, 16'h1001);
      step;
      chk16(pc, 16'h3abd);
      chk16(tr, 16'h1001);
      chk16(MEM.mem[16'h3abc], 16'h1001);
   endtask

   // Mid-run reset, then a plain word and a non-flow word after release
   task automatic t_reset;
      ld(16'h0001, 16'h6201);
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      step;
      chk16(pc, 16'h0000);
      chk16(tr, 16'h0000);
      chk1(req.we, 1'b0);
      chk1(ind, 1'b0);
      @(posedge clk_sys_i);
      reset_i <= 1'b0;
      step;
      chk16(pc, 16'h0001);
      step;
      chk16(pc, 16'h0002);
      chk16(req.addr, 16'h0002);
   endtask

   task automatic summarize;
      $display("Checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #20000;
      errors++;
      summarize;
   end

   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_program;
      t_pages;
      t_chain;
      t_reset;
      summarize;
   end
endmodule
`default_nettype wire
